// ==== common/dtp_pkg.sv ====
// Constants and types shared by the dual test port design.
// Assumes a single test clock shared by both tap controllers.
package dtp_pkg;

  // Tap controller states, Gray coded along the usual path
  typedef enum logic [3:0] {
    ST_TLR   = 4'h0,
    ST_RTI   = 4'h1,
    ST_SELDR = 4'h3,
    ST_CAPDR = 4'h2,
    ST_SHDR  = 4'h6,
    ST_EX1DR = 4'h7,
    ST_PSDR  = 4'h5,
    ST_EX2DR = 4'h4,
    ST_UPDR  = 4'hC,
    ST_SELIR = 4'hD,
    ST_CAPIR = 4'hF,
    ST_SHIR  = 4'hE,
    ST_EX1IR = 4'hA,
    ST_PSIR  = 4'hB,
    ST_EX2IR = 4'h9,
    ST_UPIR  = 4'h8
  } dtp_state_e;

  localparam int unsigned SCAN_IR_W = 4;
  localparam int unsigned DBG_IR_W  = 5;
  localparam int unsigned ID_W      = 32;
  localparam int unsigned CTRL_W    = 8;
  localparam int unsigned BSR_W     = 8;

  // Fixed low bits loaded into the instruction shifter on capture
  localparam logic [1:0] IR_CAPTURE_LSB = 2'h1;

  localparam logic [SCAN_IR_W-1:0] SCAN_OP_EXTEST = 4'h0;
  localparam logic [SCAN_IR_W-1:0] SCAN_OP_SAMPLE = 4'h1;
  localparam logic [SCAN_IR_W-1:0] SCAN_OP_IDCODE = 4'h2;
  localparam logic [SCAN_IR_W-1:0] SCAN_OP_BYPASS = 4'hF;

  localparam logic [DBG_IR_W-1:0] DBG_OP_IDCODE  = 5'h01;
  localparam logic [DBG_IR_W-1:0] DBG_OP_CONTROL = 5'h0A;
  localparam logic [DBG_IR_W-1:0] DBG_OP_BYPASS  = 5'h1F;

  // Identification words: arbitrary values
  localparam logic [ID_W-1:0] SCAN_IDCODE = 32'h0000_1001;
  localparam logic [ID_W-1:0] DBG_IDCODE  = 32'h0000_2001;

  // Debug control word layout
  localparam int unsigned          CTRL_REQ_BIT  = 0;
  localparam int unsigned          CTRL_HALT_BIT = 1;
  localparam logic [CTRL_W-1:0]    CTRL_WR_MASK  = 8'h01;
  localparam logic [CTRL_W-1:0]    CTRL_RESET    = 8'h00;
  localparam logic [BSR_W-1:0]     BSR_RESET     = 8'h00;

endpackage

// ==== hw/dtp_tap_fsm.sv ====
// Sixteen-state tap controller with its own instruction register.
// Assumes mode select and data input are already resolved on the test clock.
`timescale 1ns/10ps
`default_nettype none

module dtp_tap_fsm #(
  parameter int unsigned            IR_W     = 4,
  parameter logic [IR_W-1:0]        IR_RESET = '1
) (
  input  wire logic                 tck_i,     // Test clock
  input  wire logic                 trst_b_i,  // Async tap reset, active low
  input  wire logic                 tms_i,     // Mode select, pull-up resolved
  input  wire logic                 tdi_i,     // Serial data in
  output dtp_pkg::dtp_state_e       state_o,   // Current tap state
  output logic [IR_W-1:0]           ir_o,      // Active instruction
  output logic                      ir_tdo_o   // Instruction shifter lsb
);

  typedef struct packed {
    dtp_pkg::dtp_state_e state;
    logic [IR_W-1:0]     ir_sh;
    logic [IR_W-1:0]     ir;
  } dtp_fsm_s;

  localparam dtp_fsm_s FSM_RESET = '{state: dtp_pkg::ST_TLR, ir_sh: '0, ir: IR_RESET};

  dtp_fsm_s r;
  dtp_fsm_s next_r;

  always_comb begin
    next_r = r;
    // Standard tap graph; five edges with mode select high reach reset from anywhere [RULE11]
    case (r.state)
      dtp_pkg::ST_TLR:   next_r.state = tms_i ? dtp_pkg::ST_TLR   : dtp_pkg::ST_RTI;
      dtp_pkg::ST_RTI:   next_r.state = tms_i ? dtp_pkg::ST_SELDR : dtp_pkg::ST_RTI;
      dtp_pkg::ST_SELDR: next_r.state = tms_i ? dtp_pkg::ST_SELIR : dtp_pkg::ST_CAPDR;
      dtp_pkg::ST_CAPDR: next_r.state = tms_i ? dtp_pkg::ST_EX1DR : dtp_pkg::ST_SHDR;
      dtp_pkg::ST_SHDR:  next_r.state = tms_i ? dtp_pkg::ST_EX1DR : dtp_pkg::ST_SHDR;
      dtp_pkg::ST_EX1DR: next_r.state = tms_i ? dtp_pkg::ST_UPDR  : dtp_pkg::ST_PSDR;
      dtp_pkg::ST_PSDR:  next_r.state = tms_i ? dtp_pkg::ST_EX2DR : dtp_pkg::ST_PSDR;
      dtp_pkg::ST_EX2DR: next_r.state = tms_i ? dtp_pkg::ST_UPDR  : dtp_pkg::ST_SHDR;
      dtp_pkg::ST_UPDR:  next_r.state = tms_i ? dtp_pkg::ST_SELDR : dtp_pkg::ST_RTI;
      dtp_pkg::ST_SELIR: next_r.state = tms_i ? dtp_pkg::ST_TLR   : dtp_pkg::ST_CAPIR;
      dtp_pkg::ST_CAPIR: next_r.state = tms_i ? dtp_pkg::ST_EX1IR : dtp_pkg::ST_SHIR;
      dtp_pkg::ST_SHIR:  next_r.state = tms_i ? dtp_pkg::ST_EX1IR : dtp_pkg::ST_SHIR;
      dtp_pkg::ST_EX1IR: next_r.state = tms_i ? dtp_pkg::ST_UPIR  : dtp_pkg::ST_PSIR;
      dtp_pkg::ST_PSIR:  next_r.state = tms_i ? dtp_pkg::ST_EX2IR : dtp_pkg::ST_PSIR;
      dtp_pkg::ST_EX2IR: next_r.state = tms_i ? dtp_pkg::ST_UPIR  : dtp_pkg::ST_SHIR;
      dtp_pkg::ST_UPIR:  next_r.state = tms_i ? dtp_pkg::ST_SELDR : dtp_pkg::ST_RTI;
      default:           next_r.state = dtp_pkg::ST_TLR;
    endcase
    case (r.state)
      dtp_pkg::ST_TLR: begin
        next_r.ir = IR_RESET;
      end
      dtp_pkg::ST_CAPIR: begin
        next_r.ir_sh = {{(IR_W-2){1'b0}}, dtp_pkg::IR_CAPTURE_LSB};
      end
      dtp_pkg::ST_SHIR: begin
        next_r.ir_sh = {tdi_i, r.ir_sh[IR_W-1:1]}; // [RULE2]
      end
      dtp_pkg::ST_UPIR: begin
        next_r.ir = r.ir_sh;
      end
      default: begin
        next_r.ir = r.ir;
      end
    endcase
  end

  // Shifting on the test clock, reset without it [RULE1] [RULE9]
  always_ff @(posedge tck_i or negedge trst_b_i) begin
    if (!trst_b_i) begin
      r <= FSM_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign state_o  = r.state;
  assign ir_o     = r.ir;
  assign ir_tdo_o = r.ir_sh[0];

endmodule

`default_nettype wire

// ==== hw/dtp_top.sv ====
// Dual test port: boundary-scan tap and debug tap on one shared serial port.
// Assumes the test clock is unrelated to clk_i; pads resolve the data output
// wire from its enable, and the mode-select pull-ups are modelled here.
//
// Summary of operation
// [RULE1] All shifting in both taps and boundary logic runs on the test clock.
// [RULE2] Shared serial data input feeds both taps and the boundary register.
// [RULE3] Data output drives the shifting tap's bit, otherwise it floats.
// [RULE4] Scan mode select sequences the boundary-scan tap.
// [RULE5] Debug mode select sequences the debug tap on its own.
// [RULE6] During boundary scan the tester keeps debug mode select high.
// [RULE7] During debug the probe keeps scan mode select high.
// [RULE8] Undriven mode select inputs are pulled up to high.
// [RULE9] Low test reset clears both taps and boundary logic asynchronously.
// [RULE10] In functional use the system keeps both taps held in reset.
// [RULE11] Standard sixteen-state tap; five high mode-select edges reach reset.
`timescale 1ns/10ps
`default_nettype none

module dtp_top #(
  parameter int unsigned BSR_W  = dtp_pkg::BSR_W,
  parameter int unsigned CTRL_W = dtp_pkg::CTRL_W
) (
  input  wire logic              clk_i,                        // System clock
  input  wire logic              rst_b_i,                      // System reset, sync, active low
  input  wire logic              test_clock_i,                 // Test clock
  input  wire logic              test_reset_b_i,               // Test reset, async, active low
  input  wire logic              test_data_in_i,               // Serial data in
  output logic                   test_data_out_o,              // Serial data out
  output logic                   test_data_out_oe_b_o,         // Data out enable, low drives
  input  wire logic              scan_tap_mode_select_i,       // Scan tap mode select level
  input  wire logic              scan_tap_mode_select_oe_b_i,  // Low while tester drives it
  input  wire logic              debug_tap_mode_select_i,      // Debug tap mode select level
  input  wire logic              debug_tap_mode_select_oe_b_i, // Low while probe drives it
  input  wire logic [BSR_W-1:0]  bsr_pins_i,                   // Pin levels seen by boundary cells
  output logic [BSR_W-1:0]       bsr_drive_o,                  // Boundary update values
  output logic                   bsr_extest_o,                 // Boundary cells own the pins
  input  wire logic              cpu_halted_i,                 // Processor halted, clk_i domain
  output logic                   debug_req_o                   // Debug request, clk_i domain
);

  typedef struct packed {
    logic              s_byp;
    logic [dtp_pkg::ID_W-1:0] s_id;
    logic [BSR_W-1:0]  s_bsr_sh;
    logic [BSR_W-1:0]  s_bsr_upd;
    logic [BSR_W-1:0]  pin_s1;
    logic [BSR_W-1:0]  pin_s2;
    logic              d_byp;
    logic [dtp_pkg::ID_W-1:0] d_id;
    logic [CTRL_W-1:0] d_ctrl_sh;
    logic [CTRL_W-1:0] d_ctrl;
    logic              halt_s1;
    logic              halt_s2;
  } dtp_tck_s;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
  } dtp_sys_s;

  typedef struct packed {
    logic tdo;
    logic oe_b;
  } dtp_tdo_s;

  localparam dtp_tck_s TCK_RESET = '{
    s_byp: 1'b0, s_id: dtp_pkg::SCAN_IDCODE, s_bsr_sh: dtp_pkg::BSR_RESET,
    s_bsr_upd: dtp_pkg::BSR_RESET, pin_s1: dtp_pkg::BSR_RESET, pin_s2: dtp_pkg::BSR_RESET,
    d_byp: 1'b0, d_id: dtp_pkg::DBG_IDCODE, d_ctrl_sh: dtp_pkg::CTRL_RESET,
    d_ctrl: dtp_pkg::CTRL_RESET, halt_s1: 1'b0, halt_s2: 1'b0};
  localparam dtp_sys_s SYS_RESET = '{req_s1: 1'b0, req_s2: 1'b0};
  localparam dtp_tdo_s TDO_RESET = '{tdo: 1'b0, oe_b: 1'b1};

  dtp_tck_s                        t;
  dtp_tck_s                        next_t;
  dtp_sys_s                        c;
  dtp_sys_s                        next_c;
  dtp_tdo_s                        o;
  dtp_tdo_s                        next_o;
  logic                            scan_tms;
  logic                            dbg_tms;
  dtp_pkg::dtp_state_e             scan_state;
  dtp_pkg::dtp_state_e             dbg_state;
  logic [dtp_pkg::SCAN_IR_W-1:0]   scan_ir;
  logic [dtp_pkg::DBG_IR_W-1:0]    dbg_ir;
  logic                            scan_ir_tdo;
  logic                            dbg_ir_tdo;
  logic                            scan_dr_tdo;
  logic                            dbg_dr_tdo;
  logic                            scan_bsr_sel;

  // Pad pull-up: an undriven mode select reads high [RULE8]
  assign scan_tms = scan_tap_mode_select_oe_b_i ? 1'b1 : scan_tap_mode_select_i;
  assign dbg_tms  = debug_tap_mode_select_oe_b_i ? 1'b1 : debug_tap_mode_select_i;

  dtp_tap_fsm #(
    .IR_W     (dtp_pkg::SCAN_IR_W),
    .IR_RESET (dtp_pkg::SCAN_OP_IDCODE)
  ) u_scan_tap (
    .tck_i    (test_clock_i),
    .trst_b_i (test_reset_b_i),
    .tms_i    (scan_tms), // [RULE4]
    .tdi_i    (test_data_in_i),
    .state_o  (scan_state),
    .ir_o     (scan_ir),
    .ir_tdo_o (scan_ir_tdo)
  );

  dtp_tap_fsm #(
    .IR_W     (dtp_pkg::DBG_IR_W),
    .IR_RESET (dtp_pkg::DBG_OP_IDCODE)
  ) u_dbg_tap (
    .tck_i    (test_clock_i),
    .trst_b_i (test_reset_b_i),
    .tms_i    (dbg_tms), // [RULE5]
    .tdi_i    (test_data_in_i),
    .state_o  (dbg_state),
    .ir_o     (dbg_ir),
    .ir_tdo_o (dbg_ir_tdo)
  );

  assign scan_bsr_sel = (scan_ir == dtp_pkg::SCAN_OP_EXTEST) || (scan_ir == dtp_pkg::SCAN_OP_SAMPLE);

  // Serial bit presented by the selected data register of each tap
  assign scan_dr_tdo = scan_bsr_sel ? t.s_bsr_sh[0] :
                       (scan_ir == dtp_pkg::SCAN_OP_IDCODE) ? t.s_id[0] : t.s_byp;
  assign dbg_dr_tdo  = (dbg_ir == dtp_pkg::DBG_OP_IDCODE)  ? t.d_id[0] :
                       (dbg_ir == dtp_pkg::DBG_OP_CONTROL) ? t.d_ctrl_sh[0] : t.d_byp;

  // Test clock domain data registers
  always_comb begin
    next_t         = t;
    next_t.pin_s1  = bsr_pins_i;
    next_t.pin_s2  = t.pin_s1;
    next_t.halt_s1 = cpu_halted_i;
    next_t.halt_s2 = t.halt_s1;
    case (scan_state)
      dtp_pkg::ST_CAPDR: begin
        next_t.s_byp    = 1'b0;
        next_t.s_id     = dtp_pkg::SCAN_IDCODE;
        next_t.s_bsr_sh = scan_bsr_sel ? t.pin_s2 : t.s_bsr_sh;
      end
      dtp_pkg::ST_SHDR: begin
        // Shared serial input shifts the selected register [RULE1] [RULE2]
        if (scan_bsr_sel) begin
          next_t.s_bsr_sh = {test_data_in_i, t.s_bsr_sh[BSR_W-1:1]};
        end else if (scan_ir == dtp_pkg::SCAN_OP_IDCODE) begin
          next_t.s_id = {test_data_in_i, t.s_id[dtp_pkg::ID_W-1:1]};
        end else begin
          next_t.s_byp = test_data_in_i;
        end
      end
      dtp_pkg::ST_UPDR: begin
        next_t.s_bsr_upd = scan_bsr_sel ? t.s_bsr_sh : t.s_bsr_upd;
      end
      dtp_pkg::ST_TLR: begin
        next_t.s_bsr_upd = dtp_pkg::BSR_RESET;
      end
      default: begin
        next_t.s_byp = t.s_byp;
      end
    endcase
    case (dbg_state)
      dtp_pkg::ST_CAPDR: begin
        next_t.d_byp     = 1'b0;
        next_t.d_id      = dtp_pkg::DBG_IDCODE;
        next_t.d_ctrl_sh = t.d_ctrl;
        next_t.d_ctrl_sh[dtp_pkg::CTRL_HALT_BIT] = t.halt_s2;
      end
      dtp_pkg::ST_SHDR: begin
        if (dbg_ir == dtp_pkg::DBG_OP_IDCODE) begin
          next_t.d_id = {test_data_in_i, t.d_id[dtp_pkg::ID_W-1:1]}; // [RULE2]
        end else if (dbg_ir == dtp_pkg::DBG_OP_CONTROL) begin
          next_t.d_ctrl_sh = {test_data_in_i, t.d_ctrl_sh[CTRL_W-1:1]}; // [RULE2]
        end else begin
          next_t.d_byp = test_data_in_i; // [RULE2]
        end
      end
      dtp_pkg::ST_UPDR: begin
        if (dbg_ir == dtp_pkg::DBG_OP_CONTROL) begin
          next_t.d_ctrl = t.d_ctrl_sh & dtp_pkg::CTRL_WR_MASK;
        end
      end
      dtp_pkg::ST_TLR: begin
        next_t.d_ctrl = dtp_pkg::CTRL_RESET;
      end
      default: begin
        next_t.d_byp = t.d_byp;
      end
    endcase
  end

  // Runs on the test clock; test reset clears it without a clock edge [RULE1] [RULE9]
  always_ff @(posedge test_clock_i or negedge test_reset_b_i) begin
    if (!test_reset_b_i) begin
      t <= TCK_RESET;
    end else begin
      t <= next_t;
    end
  end

  // Output bit launched on the falling edge; enable only while shifting [RULE3]
  always_comb begin
    next_o = TDO_RESET;
    if (scan_state == dtp_pkg::ST_SHIR) begin
      next_o = '{tdo: scan_ir_tdo, oe_b: 1'b0};
    end else if (scan_state == dtp_pkg::ST_SHDR) begin
      next_o = '{tdo: scan_dr_tdo, oe_b: 1'b0};
    end else if (dbg_state == dtp_pkg::ST_SHIR) begin
      next_o = '{tdo: dbg_ir_tdo, oe_b: 1'b0};
    end else if (dbg_state == dtp_pkg::ST_SHDR) begin
      next_o = '{tdo: dbg_dr_tdo, oe_b: 1'b0};
    end
  end

  always_ff @(negedge test_clock_i or negedge test_reset_b_i) begin
    if (!test_reset_b_i) begin
      o <= TDO_RESET; // [RULE9]
    end else begin
      o <= next_o;
    end
  end

  // Debug request level into the system domain, two flops
  always_comb begin
    next_c        = c;
    next_c.req_s1 = t.d_ctrl[dtp_pkg::CTRL_REQ_BIT];
    next_c.req_s2 = c.req_s1;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      c <= SYS_RESET;
    end else begin
      c <= next_c;
    end
  end

  assign test_data_out_o      = o.tdo;
  assign test_data_out_oe_b_o = o.oe_b;
  assign bsr_drive_o          = t.s_bsr_upd;
  assign bsr_extest_o         = (scan_ir == dtp_pkg::SCAN_OP_EXTEST);
  assign debug_req_o          = c.req_s2;

endmodule

`default_nettype wire

// ==== sim/dtp_probe.sv ====
// Model of the external tester or debug probe on the shared test port.
// Assumes one task runs at a time; the test clock idles low between frames.
`timescale 1ns/10ps
`default_nettype none

module dtp_probe (
  output logic     tck_o,       // Test clock, 12 ns
  output logic     tdi_o,       // Serial data in
  output logic     sms_o,       // Scan mode select level
  output logic     sms_oe_b_o,  // Low while scan select driven
  output logic     dms_o,       // Debug mode select level
  output logic     dms_oe_b_o,  // Low while debug select driven
  input wire logic tdo_i,       // Serial data out
  input wire logic tdo_oe_b_i   // Low while device drives out
);
  logic last_tdo;

  initial begin
    tck_o = 1'b0;
    tdi_o = 1'b0;
    sms_o = 1'b1;
    sms_oe_b_o = 1'b1;
    dms_o = 1'b1;
    dms_oe_b_o = 1'b1;
    last_tdo = 1'b0;
  end

  // One test clock period; the idle select is released and wanders
  task automatic step(input logic dbg, input logic ms, input logic di, output logic do_);
    sms_oe_b_o <= dbg;
    dms_oe_b_o <= !dbg;
    sms_o      <= dbg ? !sms_o : ms;
    dms_o      <= dbg ? ms : !dms_o;
    tdi_o      <= di;
    #6 tck_o = 1'b1;
    do_ = tdo_oe_b_i ? !last_tdo : tdo_i;
    last_tdo = do_;
    #6 tck_o = 1'b0;
  endtask

  task automatic reset_tap(input logic dbg);
    logic d;
    repeat (6) step(dbg, 1'b1, 1'b0, d);
  endtask

  // From reset or idle: shift n bits through IR or DR, back to idle
  task automatic xfer(input logic dbg, input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic d;
    dout = '0;
    step(dbg, 1'b0, 1'b0, d);
    step(dbg, 1'b1, 1'b0, d);
    if (ir) step(dbg, 1'b1, 1'b0, d);
    step(dbg, 1'b0, 1'b0, d);
    step(dbg, 1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) step(dbg, i == n - 1, din[i], dout[i]);
    step(dbg, 1'b1, 1'b0, d);
    step(dbg, 1'b0, 1'b0, d);
  endtask
endmodule

`default_nettype wire

// ==== sim/dtp_top_assertions.sv ====
// Port-level checker for the dual test port, bound to dtp_top.
// Assumes the test clock stands still outside frames.
`timescale 1ns/10ps
`default_nettype none

module dtp_top_assertions #(
  parameter int unsigned BSR_W  = 8,
  parameter int unsigned CTRL_W = 8
) (
  input wire logic             clk_i,                        // System clock
  input wire logic             rst_b_i,                      // System reset
  input wire logic             test_clock_i,                 // Test clock
  input wire logic             test_reset_b_i,               // Test reset
  input wire logic             test_data_out_o,              // Serial out
  input wire logic             test_data_out_oe_b_o,         // Out enable
  input wire logic             scan_tap_mode_select_i,       // Scan select
  input wire logic             scan_tap_mode_select_oe_b_i,  // Scan driven
  input wire logic             debug_tap_mode_select_i,      // Debug select
  input wire logic             debug_tap_mode_select_oe_b_i, // Debug driven
  input wire logic [BSR_W-1:0] bsr_drive_o,                  // Boundary update
  input wire logic             bsr_extest_o,                 // Extest active
  input wire logic             debug_req_o                   // Debug request
);
  logic scan_ms;
  logic dbg_ms;
  logic any_ms_low;

  // Pull-up makes an undriven select read high
  assign scan_ms = scan_tap_mode_select_oe_b_i | scan_tap_mode_select_i;
  assign dbg_ms  = debug_tap_mode_select_oe_b_i | debug_tap_mode_select_i;
  assign any_ms_low = !scan_ms || !dbg_ms;

  property p_float_zero;
    @(negedge test_clock_i) disable iff (!test_reset_b_i) test_data_out_oe_b_o |-> !test_data_out_o;
  endproperty
  a_float_zero: assert property (p_float_zero) else $error("data out not zero while floating");

  property p_oe_cause;
    @(posedge test_clock_i) disable iff (!test_reset_b_i) $fell(test_data_out_oe_b_o) |-> $past(any_ms_low);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("data out driven without shift entry");

  property p_leave_shift;
    @(posedge test_clock_i) disable iff (!test_reset_b_i)
      !test_data_out_oe_b_o && scan_ms && dbg_ms |=> test_data_out_oe_b_o;
  endproperty
  a_leave_shift: assert property (p_leave_shift) else $error("data out still driven after shift");

  property p_five_idle;
    @(posedge test_clock_i) disable iff (!test_reset_b_i) (scan_ms && dbg_ms) [*5] |=> test_data_out_oe_b_o;
  endproperty
  a_five_idle: assert property (p_five_idle) else $error("taps not idle after five high edges");

  property p_five_reset;
    @(posedge test_clock_i) disable iff (!test_reset_b_i)
      scan_ms [*5] |-> ##2 (!bsr_extest_o && bsr_drive_o == '0);
  endproperty
  a_five_reset: assert property (p_five_reset) else $error("scan tap not reset by five high edges");

  property p_async_clear;
    @(posedge clk_i) disable iff (!rst_b_i)
      !test_reset_b_i |-> test_data_out_oe_b_o && !bsr_extest_o && bsr_drive_o == '0;
  endproperty
  a_async_clear: assert property (p_async_clear) else $error("test reset did not clear taps");

  property p_req_clear;
    @(posedge clk_i) disable iff (!rst_b_i) !test_reset_b_i [*5] |-> !debug_req_o;
  endproperty
  a_req_clear: assert property (p_req_clear) else $error("debug request survives test reset");

  property p_still;
    @(posedge clk_i) disable iff (!rst_b_i || !test_reset_b_i) $stable(test_clock_i) |->
      $stable(test_data_out_o) && $stable(test_data_out_oe_b_o) && $stable(bsr_drive_o) && $stable(bsr_extest_o);
  endproperty
  a_still: assert property (p_still) else $error("port changed without a test clock edge");

  c_shift: cover property (@(posedge test_clock_i) $fell(test_data_out_oe_b_o));
  c_req: cover property (@(posedge clk_i) $rose(debug_req_o));
  c_extest: cover property (@(posedge test_clock_i) $rose(bsr_extest_o));
endmodule

bind dtp_top dtp_top_assertions #(.BSR_W(BSR_W), .CTRL_W(CTRL_W)) u_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .test_clock_i(test_clock_i), .test_reset_b_i(test_reset_b_i),
  .test_data_out_o(test_data_out_o), .test_data_out_oe_b_o(test_data_out_oe_b_o),
  .scan_tap_mode_select_i(scan_tap_mode_select_i), .scan_tap_mode_select_oe_b_i(scan_tap_mode_select_oe_b_i),
  .debug_tap_mode_select_i(debug_tap_mode_select_i), .debug_tap_mode_select_oe_b_i(debug_tap_mode_select_oe_b_i),
  .bsr_drive_o(bsr_drive_o), .bsr_extest_o(bsr_extest_o), .debug_req_o(debug_req_o));

`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for dtp_top with a tester model on the test port.
// Assumes the checker is bound through its own file.
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic        clk_i, rst_b_i, tck, trst_b, tdi, tdo, tdo_oe_b, sms, sms_oe_b, dms, dms_oe_b;
  logic        extest, halted, dreq;
  logic [7:0]  pins, drive;
  logic [31:0] got;
  int          errors, check_count;

  dtp_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .test_clock_i(tck), .test_reset_b_i(trst_b),
    .test_data_in_i(tdi), .test_data_out_o(tdo), .test_data_out_oe_b_o(tdo_oe_b),
    .scan_tap_mode_select_i(sms), .scan_tap_mode_select_oe_b_i(sms_oe_b), .debug_tap_mode_select_i(dms),
    .debug_tap_mode_select_oe_b_i(dms_oe_b), .bsr_pins_i(pins), .bsr_drive_o(drive),
    .bsr_extest_o(extest), .cpu_halted_i(halted), .debug_req_o(dreq));

  dtp_probe probe (.tck_o(tck), .tdi_o(tdi), .sms_o(sms), .sms_oe_b_o(sms_oe_b), .dms_o(dms),
    .dms_oe_b_o(dms_oe_b), .tdo_i(tdo), .tdo_oe_b_i(tdo_oe_b));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wait_req(input logic val);
    int n;
    n = 0;
    while (dreq !== val && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("debug_req_o", dreq, val);
    if (dreq !== val) finish_test();
  endtask

  task automatic t_scan();
    probe.xfer(1'b0, 1'b0, 32, 32'h0, got);
    chk("scan id", got, dtp_pkg::SCAN_IDCODE);
    probe.xfer(1'b0, 1'b1, 4, {28'h0, dtp_pkg::SCAN_OP_BYPASS}, got);
    chk("scan ir capture", got[1:0], dtp_pkg::IR_CAPTURE_LSB);
    probe.xfer(1'b0, 1'b0, 32, 32'h1234_5678, got);
    chk("scan bypass", got, 32'h2468_ACF0);
    $display("test t_scan done");
  endtask

  task automatic t_debug();
    probe.xfer(1'b1, 1'b0, 32, 32'h0, got);
    chk("debug id", got, dtp_pkg::DBG_IDCODE);
    probe.xfer(1'b1, 1'b1, 5, {27'h0, dtp_pkg::DBG_OP_BYPASS}, got);
    chk("debug ir capture", got[1:0], dtp_pkg::IR_CAPTURE_LSB);
    probe.xfer(1'b1, 1'b0, 8, 32'h81, got);
    chk("debug bypass", got[7:0], 8'h02);
    $display("test t_debug done");
  endtask

  task automatic t_bound();
    probe.xfer(1'b0, 1'b1, 4, {28'h0, dtp_pkg::SCAN_OP_EXTEST}, got);
    chk("extest", extest, 1'b1);
    probe.xfer(1'b0, 1'b0, 8, 32'h3C, got);
    chk("pins captured", got[7:0], pins);
    chk("drive", drive, 8'h3C);
    probe.reset_tap(1'b0);
    chk("extest after reset", extest, 1'b0);
    chk("drive after reset", drive, 8'h00);
    @(posedge clk_i);
    pins <= 8'h5A;
    probe.xfer(1'b0, 1'b1, 4, {28'h0, dtp_pkg::SCAN_OP_SAMPLE}, got);
    chk("extest in sample", extest, 1'b0);
    probe.xfer(1'b0, 1'b0, 8, 32'h0, got);
    chk("pins sampled", got[7:0], 8'h5A);
    $display("test t_bound done");
  endtask

  task automatic t_ctrl();
    logic d;
    probe.xfer(1'b1, 1'b1, 5, {27'h0, dtp_pkg::DBG_OP_CONTROL}, got);
    probe.xfer(1'b1, 1'b0, 8, 32'h01, got);
    chk("control capture", got[7:0], 8'h02);
    wait_req(1'b1);
    // Stop inside Shift-DR so the test reset meets a driven output
    probe.step(1'b1, 1'b1, 1'b0, d);
    probe.step(1'b1, 1'b0, 1'b0, d);
    probe.step(1'b1, 1'b0, 1'b0, d);
    #1;
    chk("oe while shifting", tdo_oe_b, 1'b0);
    chk("control bit 0 out", tdo, 1'b1);
    @(posedge clk_i);
    trst_b <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    chk("oe after test reset", tdo_oe_b, 1'b1);
    chk("data out after test reset", tdo, 1'b0);
    wait_req(1'b0);
    @(posedge clk_i);
    trst_b <= 1'b1;
    probe.xfer(1'b1, 1'b0, 32, 32'h0, got);
    chk("debug id after test reset", got, dtp_pkg::DBG_IDCODE);
    $display("test t_ctrl done");
  endtask

  initial begin
    #200000;
    errors++;
    finish_test();
  end

  initial begin
    errors = 0;
    check_count = 0;
    rst_b_i = 1'b0;
    trst_b = 1'b0;
    pins = 8'hA5;
    halted = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    trst_b <= 1'b1;
    @(posedge clk_i);
    #1.3;
    t_scan();
    t_debug();
    t_bound();
    t_ctrl();
    finish_test();
  end
endmodule

`default_nettype wire
